// file: core/bcs_pkg.sv
// constants for the broadband collision and quality-test timing block
package bcs_pkg;
	// bit time and clock, in their own units
	localparam int CLK_NS        = 10;
	localparam int BIT_NS        = 100;
	localparam int CYC_PER_BIT   = BIT_NS / CLK_NS;
	localparam int CYC_HALF_BIT  = CYC_PER_BIT / 2;
	localparam int DIV_W         = 4;
	// counter width for bit-time counts
	localparam int CNT_W         = 10;
	// documented limits, in bit times
	localparam int TX_LAT_MAX_BT = 24;
	localparam int LCL_CE_MAX_BT = 32;
	localparam int SQE_DLY_BT    = 35;
	localparam int SQE_DLY_TOL   = 3;
	localparam int SQE_LEN_BT    = 30;
	localparam int SQE_LEN_TOL   = 1;
	localparam int RX_LAT_MAX_BT = 75;
	localparam int CE_RISE_MAX_BT = 34;
	localparam int CI_FIRST_MAX_BT = 27;
	localparam int CI_OFF_MAX_BT = 31;
	localparam int CI_MIN_BT     = 5;
	localparam int SQE_GAP_MIN_BT = 6;
	localparam int SQE_GAP_MAX_BT = 16;
	localparam int SQE_CI_BT     = 10;
	localparam int PRE_LOSS_MAX  = 6;
	localparam int POST_ONES     = 22;
	// working values chosen inside the limits
	localparam int TX_LAT_BT     = 8;
	localparam int RX_LAT_BT     = 16;
	localparam int CI_HOLD_BT    = 4;
	localparam int SQE_GAP_BT    = 11;
	localparam int CE_JAM_BT     = 64;
	localparam int CED_BT        = 576;
	// reset values
	localparam logic RST_LVL     = 1'b0;

	typedef enum logic [2:0] {
		BCS_TX_IDLE,
		BCS_TX_DATA,
		BCS_TX_POST,
		BCS_TX_SQE_WAIT,
		BCS_TX_SQE
	} bcs_tx_st_t;
endpackage

// file: core/bcs_bit_timer.sv
// bit-rate enable generator: start-of-bit and mid-bit pulses
`timescale 1ns/1ns
module bcs_bit_timer
	import bcs_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	output logic      bit_tick,
	output logic      half_tick
);
	logic [DIV_W-1:0] div_ff;

	// counter is cleared by reset and free-runs at the clock rate, wrapping once per bit time; see R24
	always_ff @(posedge clk) begin
		if (rst) begin
			div_ff <= '0;
		end else if (div_ff == DIV_W'(CYC_PER_BIT - 1)) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + 1'b1;
		end
	end

	assign bit_tick  = (div_ff == DIV_W'(CYC_PER_BIT - 1));
	assign half_tick = (div_ff == DIV_W'(CYC_HALF_BIT - 1));
endmodule // bcs_bit_timer

// file: core/bcs_collision_sqe.sv
// collision presence, quality-test and latency timing of the coax unit
// Summary of operation
// R1: own quality-test burst seen on RF drives collision presence in time.
// R2: no quality-test indication unless the burst is really seen on RF.
// R3: collision presence on at first enforcement, held until RF activity ends.
// R4: short own packet plus own burst: band energy is not a collision.
// R5: receive packet equals transmit; at most one extra, six lost bits.
// R6: receive circuit stays Manchester encoded even during collisions.
// R7: transmit bit to RF phase change latency at most 24 bit times.
// R8: carrier before transmit start: local collision, enforcement within 32.
// R9: quality-test burst starts 35 plus or minus 3 after postamble start.
// R10: quality-test burst lasts 30 plus or minus 1 bit times.
// R11: start delimiter to receive circuit latency at most 75 bit times.
// R12: comparison mismatch: enforcement rises within 34 bit times.
// R13: comparison mismatch: first collision transition within 27 bit times.
// R14: comparison collision: presence quiet within 31 after both bands idle.
// R15: remote enforcement: first presence transition within 31 bit times.
// R16: remote enforcement: presence at least 5, off within 31 after idle.
// R17: enforcement after window or after own burst is a quality test.
// R18: passing test: presence starts 6 to 16 after last receive transition.
// R19: passing test: presence lasts 10 plus or minus 5 bit times.
// R20: only the transmitting unit signals a passing quality test.
// R21: enforcement inside the open window is a true collision.
// R22: postamble is one zero then 22 ones, unscrambled, after data.
// R23: window length is a parameter counted from data energy, flag shown.
// R24: latency counters run at bit rate, reset, restart per packet.
`timescale 1ns/1ns
module bcs_collision_sqe
	import bcs_pkg::*;
#(
	parameter int TX_LAT = TX_LAT_BT,
	parameter int RX_LAT = RX_LAT_BT,
	parameter int CED_WINDOW = CED_BT,
	parameter int CE_JAM = CE_JAM_BT
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic do_active,
	input  wire logic do_bit,
	input  wire logic rx_valid,
	input  wire logic rx_bit,
	input  wire logic rf_data_det,
	input  wire logic rf_ce_det,
	input  wire logic cmp_mismatch,
	output logic      rf_tx_en,
	output logic      rf_tx_data,
	output logic      ce_tx_en,
	output logic      sqe_burst,
	output logic      end_delim_start,
	output logic      di_active,
	output logic      di_out,
	output logic      ci_active,
	output logic      ci_out,
	output logic      ced_open,
	output logic      collision
);
	logic                bit_tick;
	logic                half_tick;
	logic [TX_LAT-1:0]   tx_dly_bit_ff;
	logic [TX_LAT-1:0]   tx_dly_act_ff;
	logic [RX_LAT-1:0]   rx_dly_bit_ff;
	logic [RX_LAT-1:0]   rx_dly_val_ff;
	bcs_tx_st_t          tx_st_ff;
	logic [CNT_W-1:0]    tx_cnt_ff;
	logic                rf_tx_en_ff;
	logic                rf_tx_data_ff;
	logic                end_delim_ff;
	logic                sqe_sent_ff;
	logic                do_act_prev_ff;
	logic                ce_prev_ff;
	logic                data_prev_ff;
	logic [CNT_W-1:0]    ced_cnt_ff;
	logic                ced_open_ff;
	logic                coll_ff;
	logic [CNT_W-1:0]    jam_cnt_ff;
	logic                ci_coll_ff;
	logic [CNT_W-1:0]    ci_min_ff;
	logic [CNT_W-1:0]    ci_hold_ff;
	logic                sqe_pend_ff;
	logic                sqe_ci_ff;
	logic [CNT_W-1:0]    sqe_cnt_ff;
	logic                di_act_ff;
	logic                di_bit_ff;
	logic                di_out_ff;
	logic                ci_out_ff;
	logic                ce_rise;
	logic                tx_start;
	logic                lcl_coll;
	logic                is_sqe;
	logic                rf_busy;

	bcs_bit_timer bcs_bit_timer_inst (
		.clk       (clk),
		.rst       (rst),
		.bit_tick  (bit_tick),
		.half_tick (half_tick)
	);

	assign tx_start = do_active & ~do_act_prev_ff;
	assign ce_rise  = rf_ce_det & ~ce_prev_ff;
	assign rf_busy  = rf_data_det | rf_ce_det;
	// carrier already present as the station begins; see R8
	assign lcl_coll = tx_start & rf_data_det;
	// own burst sent, or window shut: energy is a quality test; see R17 R4
	assign is_sqe   = ~ced_open_ff | sqe_sent_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			do_act_prev_ff <= RST_LVL;
			ce_prev_ff     <= RST_LVL;
			data_prev_ff   <= RST_LVL;
		end else begin
			do_act_prev_ff <= do_active;
			ce_prev_ff     <= rf_ce_det;
			data_prev_ff   <= rf_data_det;
		end
	end

	// fixed transmit latency well under the limit; see R7
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_dly_bit_ff <= '0;
			tx_dly_act_ff <= '0;
		end else if (bit_tick) begin
			tx_dly_bit_ff <= {tx_dly_bit_ff[TX_LAT-2:0], do_bit};
			tx_dly_act_ff <= {tx_dly_act_ff[TX_LAT-2:0], do_active};
		end
	end

	// transmit framing: data, postamble, then the quality-test burst
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_st_ff      <= BCS_TX_IDLE;
			tx_cnt_ff     <= '0;
			rf_tx_en_ff   <= 1'b0;
			rf_tx_data_ff <= 1'b1;
			end_delim_ff  <= 1'b0;
			sqe_sent_ff   <= 1'b0;
		end else begin
			end_delim_ff <= 1'b0;
			if (tx_start | (rf_data_det & ~data_prev_ff)) begin // see R20
				sqe_sent_ff <= 1'b0;
			end
			if (bit_tick) begin
				case (tx_st_ff)
				BCS_TX_IDLE: begin
					rf_tx_en_ff <= 1'b0;
					if (tx_dly_act_ff[TX_LAT-1]) begin
						tx_st_ff      <= BCS_TX_DATA;
						rf_tx_en_ff   <= 1'b1;
						rf_tx_data_ff <= tx_dly_bit_ff[TX_LAT-1];
					end
				end
				BCS_TX_DATA: begin
					if (tx_dly_act_ff[TX_LAT-1]) begin
						rf_tx_data_ff <= tx_dly_bit_ff[TX_LAT-1];
					end else begin
						// zero opens the postamble; see R22
						tx_st_ff      <= BCS_TX_POST;
						tx_cnt_ff     <= '0;
						rf_tx_data_ff <= 1'b0;
						end_delim_ff  <= 1'b1;
					end
				end
				BCS_TX_POST: begin
					tx_cnt_ff     <= tx_cnt_ff + 1'b1;
					rf_tx_data_ff <= 1'b1;
					if (tx_cnt_ff == CNT_W'(POST_ONES)) begin
						rf_tx_en_ff <= 1'b0;
						tx_st_ff    <= BCS_TX_SQE_WAIT;
					end
				end
				BCS_TX_SQE_WAIT: begin
					tx_cnt_ff <= tx_cnt_ff + 1'b1;
					// burst timed from postamble start; see R9
					if (coll_ff) begin
						tx_st_ff <= BCS_TX_IDLE;
					end else if (tx_cnt_ff == CNT_W'(SQE_DLY_BT - 1)) begin
						tx_st_ff    <= BCS_TX_SQE;
						sqe_sent_ff <= 1'b1;
					end
				end
				BCS_TX_SQE: begin
					tx_cnt_ff <= tx_cnt_ff + 1'b1;
					// burst length; see R10
					if (tx_cnt_ff == CNT_W'(SQE_DLY_BT + SQE_LEN_BT - 1)) begin
						tx_st_ff <= BCS_TX_IDLE;
					end
				end
				default: begin
					tx_st_ff <= BCS_TX_IDLE;
				end
				endcase
			end
		end
	end

	// window restarts with each packet's first data-band energy; see R23 R24
	always_ff @(posedge clk) begin
		if (rst) begin
			ced_cnt_ff  <= '0;
			ced_open_ff <= 1'b0;
		end else if (rf_data_det & ~data_prev_ff) begin
			ced_cnt_ff  <= '0;
			ced_open_ff <= 1'b1;
		end else if (bit_tick & ced_open_ff) begin
			ced_cnt_ff <= ced_cnt_ff + 1'b1;
			if (ced_cnt_ff == CNT_W'(CED_WINDOW - 1)) begin
				ced_open_ff <= 1'b0;
			end
		end
	end

	// collision and enforcement jam; immediate start keeps R12 margin
	always_ff @(posedge clk) begin
		if (rst) begin
			coll_ff    <= 1'b0;
			jam_cnt_ff <= '0;
		end else begin
			if (lcl_coll | (cmp_mismatch & do_active)) begin
				coll_ff    <= 1'b1; // see R8 R12
				jam_cnt_ff <= CNT_W'(CE_JAM);
			end else if (ce_rise & ~is_sqe) begin
				coll_ff <= 1'b1; // see R21
			end else if (tx_start) begin
				coll_ff <= 1'b0;
			end else if (bit_tick & (jam_cnt_ff != '0)) begin
				jam_cnt_ff <= jam_cnt_ff - 1'b1;
			end
		end
	end

	// presence for collisions: on at once, minimum hold, trailing hold
	always_ff @(posedge clk) begin
		if (rst) begin
			ci_coll_ff <= 1'b0;
			ci_min_ff  <= '0;
			ci_hold_ff <= '0;
		end else if (lcl_coll | (cmp_mismatch & do_active) |
			(ce_rise & ~is_sqe)) begin
			ci_coll_ff <= 1'b1; // see R3 R13 R15
			ci_min_ff  <= CNT_W'(CI_MIN_BT);
			ci_hold_ff <= CNT_W'(CI_HOLD_BT);
		end else if (bit_tick & ci_coll_ff) begin
			if (ci_min_ff != '0) begin
				ci_min_ff <= ci_min_ff - 1'b1; // see R16
			end
			if (rf_busy | (jam_cnt_ff != '0)) begin
				ci_hold_ff <= CNT_W'(CI_HOLD_BT); // see R3
			end else if (ci_hold_ff != '0) begin
				ci_hold_ff <= ci_hold_ff - 1'b1;
			end else if (ci_min_ff == '0) begin
				ci_coll_ff <= 1'b0; // see R14 R16
			end
		end
	end

	// quality-test presence: only the sender, only on energy really seen
	always_ff @(posedge clk) begin
		if (rst) begin
			sqe_pend_ff <= 1'b0;
			sqe_ci_ff   <= 1'b0;
			sqe_cnt_ff  <= '0;
		end else if (ce_rise & is_sqe & sqe_sent_ff & ~coll_ff) begin
			sqe_pend_ff <= 1'b1; // see R1 R2 R20
			sqe_cnt_ff  <= '0;
		end else if (tx_start) begin
			sqe_pend_ff <= 1'b0;
			sqe_ci_ff   <= 1'b0;
		end else if (bit_tick) begin
			if (sqe_pend_ff & ~di_act_ff) begin
				sqe_cnt_ff <= sqe_cnt_ff + 1'b1;
				// gap after the last receive transition; see R18
				if (sqe_cnt_ff == CNT_W'(SQE_GAP_BT - 1)) begin
					sqe_pend_ff <= 1'b0;
					sqe_ci_ff   <= 1'b1;
					sqe_cnt_ff  <= '0;
				end
			end else if (sqe_pend_ff) begin
				sqe_cnt_ff <= '0;
			end else if (sqe_ci_ff) begin
				sqe_cnt_ff <= sqe_cnt_ff + 1'b1;
				if (sqe_cnt_ff == CNT_W'(SQE_CI_BT - 1)) begin
					sqe_ci_ff <= 1'b0; // see R19
				end
			end
		end
	end

	// receive path: fixed delay, bits passed unchanged; see R5 R11
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_dly_bit_ff <= '0;
			rx_dly_val_ff <= '0;
			di_act_ff     <= 1'b0;
			di_bit_ff     <= 1'b1;
		end else if (bit_tick) begin
			rx_dly_bit_ff <= {rx_dly_bit_ff[RX_LAT-2:0], rx_bit};
			rx_dly_val_ff <= {rx_dly_val_ff[RX_LAT-2:0], rx_valid};
			di_act_ff     <= rx_dly_val_ff[RX_LAT-1];
			di_bit_ff     <= rx_dly_bit_ff[RX_LAT-1];
		end
	end

	// manchester coding whatever the data; idle after the frame; see R6
	always_ff @(posedge clk) begin
		if (rst) begin
			di_out_ff <= 1'b0;
		end else if (~di_act_ff) begin
			di_out_ff <= 1'b0;
		end else if (bit_tick) begin
			di_out_ff <= ~rx_dly_bit_ff[RX_LAT-1];
		end else if (half_tick) begin
			di_out_ff <= di_bit_ff;
		end
	end

	// presence toggles every half bit; first edge within one bit of cause
	always_ff @(posedge clk) begin
		if (rst) begin
			ci_out_ff <= 1'b0;
		end else if (~(ci_coll_ff | sqe_ci_ff)) begin
			ci_out_ff <= 1'b0;
		end else if (bit_tick | half_tick) begin
			ci_out_ff <= ~ci_out_ff;
		end
	end

	assign rf_tx_en        = rf_tx_en_ff;
	assign rf_tx_data      = rf_tx_data_ff;
	assign sqe_burst       = (tx_st_ff == BCS_TX_SQE);
	assign ce_tx_en        = sqe_burst | (jam_cnt_ff != '0);
	assign end_delim_start = end_delim_ff;
	assign di_active       = di_act_ff;
	assign di_out          = di_out_ff;
	assign ci_active       = ci_coll_ff | sqe_ci_ff;
	assign ci_out          = ci_out_ff;
	assign ced_open        = ced_open_ff;
	assign collision       = coll_ff;
endmodule // bcs_collision_sqe

// file: sim/bcs_station_model.sv
// station model driving the transmit circuit of the coax unit
`timescale 1ns/1ns
module bcs_station_model (
	input  wire logic       clk,
	input  wire logic       start,
	input  wire logic [9:0] len,
	output logic            do_active,
	output logic            do_bit
);
	logic go_ff = 1'b0;
	int   left  = 0;
	initial begin
		do_active = 1'b0;
		do_bit = 1'b0;
	end
	// start is taken on the rising edge so the falling-edge driver never races it
	always @(posedge clk) begin
		go_ff <= start;
	end
	always @(negedge clk) begin
		if (go_ff) begin
			left = len * 10;
		end
		if (left > 0) begin
			do_active = 1'b1;
			do_bit = 1'((left / 10) % 2);
			left--;
		end else begin
			// idle line toggles so a stale bit is never mistaken for data
			do_active = 1'b0;
			do_bit = ~do_bit;
		end
	end
endmodule // bcs_station_model

// file: sim/bcs_collision_sqe_checker.sv
// port assertions for the collision and quality-test timing block
`timescale 1ns/1ns
module bcs_collision_sqe_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic do_active,
	input wire logic rf_data_det,
	input wire logic rf_ce_det,
	input wire logic cmp_mismatch,
	input wire logic rf_tx_en,
	input wire logic rf_tx_data,
	input wire logic ce_tx_en,
	input wire logic sqe_burst,
	input wire logic end_delim_start,
	input wire logic ci_active,
	input wire logic ci_out,
	input wire logic ced_open,
	input wire logic collision
);
	logic [11:0] ci_cnt_ff;
	logic [11:0] sqe_cnt_ff;
	logic [11:0] idle_cnt_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	always_ff @(posedge clk) begin
		ci_cnt_ff <= (rst || !ci_active) ? 12'h000 : ci_cnt_ff + 12'h001;
	end
	always_ff @(posedge clk) begin
		sqe_cnt_ff <= (rst || !sqe_burst) ? 12'h000 : sqe_cnt_ff + 12'h001;
	end
	// saturates so a long quiet spell cannot wrap into a false short one
	always_ff @(posedge clk) begin
		if (rst || rf_data_det || rf_ce_det || ce_tx_en) begin
			idle_cnt_ff <= 12'h000;
		end else begin
			idle_cnt_ff <= idle_cnt_ff + {11'h000, ~&idle_cnt_ff};
		end
	end
	AST_LOCAL: assert property ($rose(do_active) && rf_data_det
		|=> collision && ce_tx_en) else $error("local collision missed");
	AST_MISMATCH: assert property (do_active && cmp_mismatch
		|=> collision && ci_active && ce_tx_en) else $error("mismatch missed");
	AST_CI_WAVE: assert property ($rose(ci_active)
		|-> ##[1:10] $changed(ci_out)) else $error("presence wave late");
	AST_CI_MIN: assert property ($fell(ci_active) && collision
		|-> ci_cnt_ff >= 12'h032) else $error("presence too short");
	AST_CI_OFF: assert property (collision && idle_cnt_ff > 12'h136
		|-> !ci_active) else $error("presence held too long");
	AST_SQE_CI: assert property ($fell(ci_active) && !collision
		|-> ci_cnt_ff >= 12'h032 && ci_cnt_ff <= 12'h096)
		else $error("test presence length");
	AST_SQE_LEN: assert property ($fell(sqe_burst)
		|-> sqe_cnt_ff >= 12'h122 && sqe_cnt_ff <= 12'h136)
		else $error("test burst length");
	AST_SQE_DLY: assert property (end_delim_start && !collision
		|-> ##[320:380] $rose(sqe_burst)) else $error("test burst delay");
	AST_POST: assert property (end_delim_start
		|-> ##1 (rf_tx_en && !rf_tx_data) ##[1:10] rf_tx_data)
		else $error("postamble start");
	AST_CED: assert property ($rose(rf_data_det) && !ced_open
		|=> ced_open) else $error("window not opened");
endmodule // bcs_collision_sqe_checker

// file: sim/testbench.sv
// self-checking bench for the collision and quality-test timing block
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin \
	failures++; $display("wrong value at %0t: %s", $time, msg); end end
module testbench;
	typedef struct {
		int   len, d_on, d_off, c_on, c_off, mis;
		logic loop, col, ci;
	} bcs_row_t;
	// length, outside carrier, outside enforcement, mismatch, loop, expected
	bcs_row_t rows [7] = '{
		'{150, 0, 0, 0, 0, -1, 1'b1, 1'b0, 1'b1},
		'{20, 0, 0, 0, 0, -1, 1'b1, 1'b0, 1'b1},
		'{150, 0, 0, 0, 0, -1, 1'b0, 1'b0, 1'b0},
		'{150, 0, 0, 0, 0, 400, 1'b1, 1'b1, 1'b1},
		'{150, 0, 0, 300, 400, -1, 1'b1, 1'b1, 1'b1},
		'{150, 0, 400, 0, 0, -1, 1'b1, 1'b1, 1'b1},
		'{0, 0, 1500, 1200, 1500, -1, 1'b0, 1'b0, 1'b0}};
	logic       clk, rst, start, rf_data_det, rf_ce_det;
	logic       rx_valid, rx_bit, cmp_mismatch, do_active, do_bit;
	logic       rf_tx_en, rf_tx_data, ce_tx_en, sqe_burst, end_delim_start;
	logic       di_active, di_out, ci_active, ci_out, ced_open, collision;
	logic [9:0] len;
	int         failures = 0;
	int         n_tests = 0;
	int         cycles = 0;
	bcs_station_model bcs_station_model_inst (.clk(clk), .start(start),
		.len(len), .do_active(do_active), .do_bit(do_bit));
	// window cut to 100 bit times so only a short packet's own burst still lands inside it
	bcs_collision_sqe #(.CED_WINDOW(100), .CE_JAM(8)) bcs_collision_sqe_inst (
		.clk(clk), .rst(rst), .do_active(do_active), .do_bit(do_bit),
		.rx_valid(rx_valid), .rx_bit(rx_bit), .rf_data_det(rf_data_det),
		.rf_ce_det(rf_ce_det), .cmp_mismatch(cmp_mismatch),
		.rf_tx_en(rf_tx_en), .rf_tx_data(rf_tx_data), .ce_tx_en(ce_tx_en),
		.sqe_burst(sqe_burst), .end_delim_start(end_delim_start),
		.di_active(di_active), .di_out(di_out), .ci_active(ci_active),
		.ci_out(ci_out), .ced_open(ced_open), .collision(collision));
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			report_and_stop();
		end
	end
	initial begin
		bcs_row_t r;
		int       t_tx, t_ci, t_di, n_edge, n_di, n_en;
		logic     col, ci, di_prev;
		rst = 1'b1;
		start = 1'b0;
		len = 10'h000;
		rf_data_det = 1'b0;
		rf_ce_det = 1'b0;
		rx_valid = 1'b0;
		rx_bit = 1'b0;
		cmp_mismatch = 1'b0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		foreach (rows[i]) begin
			// fresh start per row: a collision stands until the next own packet
			rst = 1'b1;
			repeat (2) @(negedge clk);
			rst = 1'b0;
			r = rows[i];
			n_edge = 0;
			n_di = 0;
			n_en = 0;
			di_prev = 1'b0;
			t_tx = -1;
			t_ci = -1;
			t_di = -1;
			col = 1'b0;
			ci = 1'b0;
			len = r.len[9:0];
			// the far side echoes our own RF back when loop is set
			for (int c = 0; c < 3000; c++) begin
				@(negedge clk);
				start = (c == 5) && (r.len != 0);
				rf_data_det = (c >= r.d_on && c < r.d_off) | (r.loop & rf_tx_en);
				rf_ce_det = (c >= r.c_on && c < r.c_off) | (r.loop & ce_tx_en);
				rx_valid = r.loop & rf_tx_en;
				rx_bit = rf_tx_en ? rf_tx_data : ~rx_bit;
				cmp_mismatch = (c == r.mis);
				if (rf_tx_en === 1'b1 && t_tx < 0) t_tx = c;
				if (ci_active === 1'b1 && t_ci < 0) t_ci = c;
				if (di_active === 1'b1) t_di = c;
				col = col | collision;
				ci = ci | ci_active;
				if (di_active === 1'b1 && di_out !== di_prev) n_edge++;
				if (di_active === 1'b1) n_di++;
				if (rx_valid === 1'b1) n_en++;
				di_prev = di_out;
			end
			`CHK(n_edge >= n_di / 10 - 1, 1'b1, "receive coding")
			`CHK(n_en - n_di <= 60 && n_di - n_en <= 10, 1'b1, "length")
			`CHK(col, r.col, "collision flag")
			`CHK(ci, r.ci, "presence seen")
			if (r.ci && !r.col) begin
				`CHK(t_tx <= 245, 1'b1, "transmit latency")
				`CHK(t_ci - t_di >= 60 && t_ci - t_di <= 160, 1'b1, "gap")
			end
			$display("row %0d done", i);
		end
		len = 10'h096;
		@(negedge clk) start = 1'b1;
		@(negedge clk) start = 1'b0;
		repeat (500) @(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		`CHK({rf_tx_en, ce_tx_en, ci_active, collision, ced_open, di_active},
			6'h00, "reset outputs")
		`CHK(rf_tx_data, 1'b1, "reset data level")
		rst = 1'b0;
		repeat (20) @(negedge clk);
		$display("reset test done");
		report_and_stop();
	end
endmodule // testbench
bind bcs_collision_sqe bcs_collision_sqe_checker bcs_collision_sqe_checker_inst (
	.clk(clk), .rst(rst), .do_active(do_active), .rf_data_det(rf_data_det),
	.rf_ce_det(rf_ce_det), .cmp_mismatch(cmp_mismatch), .rf_tx_en(rf_tx_en),
	.rf_tx_data(rf_tx_data), .ce_tx_en(ce_tx_en), .sqe_burst(sqe_burst),
	.end_delim_start(end_delim_start), .ci_active(ci_active),
	.ci_out(ci_out), .ced_open(ced_open), .collision(collision));
